// *** inc/rfseq_pkg.sv ***
// Purpose: Shared constants for the transceiver power sequencer ends
// Assumes: 10 MHz system clock on both ends
// Notes:   Device register map, field codes, host command codes, timing
package rfseq_pkg;
  // Device register indices on the configuration link
  localparam logic [3:0] REG_MAIN   = 4'h0;
  localparam logic [3:0] REG_DEV    = 4'h1;
  localparam logic [3:0] REG_GAIN2  = 4'h2;
  localparam logic [3:0] REG_GAIN4  = 4'h3;
  localparam logic [3:0] REG_BIAS   = 4'h4;
  localparam logic [3:0] REG_IFACE  = 4'h5;
  localparam logic [3:0] REG_MODEM  = 4'h6;
  localparam logic [3:0] REG_FILTER = 4'h7;
  localparam logic [3:0] REG_CAL    = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'h9;
  localparam int         NUM_REGS   = 9;
  // Power control register fields
  localparam int MAIN_RX_PD   = 0;
  localparam int MAIN_TX_PD   = 1;
  localparam int MAIN_FS_PD   = 2;
  localparam int MAIN_XOSC_PD = 3;
  localparam int MAIN_RESET_N = 4;
  localparam int MAIN_TX_MODE = 5;
  localparam int MAIN_WORD2   = 6;
  // Power control values used by the sequences
  localparam logic [7:0] MAIN_RESET_VAL = 8'h0f;
  localparam logic [7:0] MAIN_PD_VAL    = 8'h1f;
  localparam logic [7:0] MAIN_WAKE_RX   = 8'h13;
  localparam logic [7:0] MAIN_WAKE_TX   = 8'h73;
  localparam logic [7:0] MAIN_SETUP_RX  = 8'h12;
  localparam logic [7:0] MAIN_SETUP_TX  = 8'h71;
  // Other register reset values
  localparam logic [7:0] DEV_RST    = 8'h54;
  localparam logic [7:0] GAIN2_RST  = 8'h01;
  localparam logic [7:0] GAIN4_RST  = 8'h40;
  localparam logic [7:0] BIAS_RST   = 8'h86; // Distinct nibbles so the active word shows
  localparam logic [7:0] IFACE_RST  = 8'h00;
  localparam logic [7:0] MODEM_RST  = 8'h02;
  localparam logic [7:0] FILTER_RST = 8'h00;
  // Field positions and codes
  localparam logic [3:0] DEV_MANT_OOK   = 4'h0;
  localparam logic [1:0] GAIN_AVG_OOK   = 2'h3;
  localparam int         IFACE_REF_SKIP = 0;
  localparam int         MODEM_MANCH    = 0;
  localparam int         MODEM_TRACK    = 1;
  localparam int         MODEM_BAUD_LSB = 2;
  localparam logic [1:0] FILT_X4        = 2'h2;
  localparam logic [1:0] FILT_X2        = 2'h1;
  localparam logic [2:0] BAUD_9K6_IDX   = 3'h2;
  localparam int         CAL_START      = 0;
  localparam int         STAT_CAL_DONE  = 0;
  localparam int         STAT_LOCK      = 1;
  // Host register offsets and fields
  localparam logic [1:0] HOST_CMD    = 2'h0;
  localparam logic [1:0] HOST_CFG    = 2'h1;
  localparam logic [1:0] HOST_STATUS = 2'h2;
  localparam logic [1:0] CMD_INIT    = 2'h0;
  localparam logic [1:0] CMD_RX      = 2'h1;
  localparam logic [1:0] CMD_TX      = 2'h2;
  localparam logic [1:0] CMD_PD      = 2'h3;
  localparam logic [7:0] CFG_RST     = 8'h00;
  // Timing
  localparam int CLK_MHZ        = 10;
  localparam int RELOCK_US      = 1300;
  localparam int RELOCK_CYCLES  = RELOCK_US * CLK_MHZ;
  localparam int CAL_CYCLES     = 1000;
  localparam int LOCK_CYCLES    = 280;
  // Host program operations
  typedef enum logic [1:0] {OP_WR, OP_CAL, OP_RELOCK, OP_END} op_t;
  typedef enum logic [1:0] {M_UNINIT, M_PD, M_RX, M_TX} mode_t;
endpackage : rfseq_pkg

// *** inc/rf_cfg_if.sv ***
// Purpose: Configuration link between host sequencer and transceiver
// Assumes: One clock; one transaction in flight at a time
// Notes:   Device answers every selected strobe with a one-cycle ack
`timescale 1ns/1ns
interface rf_cfg_if;
  logic       sel_n;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       ack;
  modport host   (output sel_n, addr, wdata, wr, rd, input rdata, ack);
  modport device (input sel_n, addr, wdata, wr, rd, output rdata, ack);
endinterface : rf_cfg_if

// *** hdl/rf_device_end.sv ***
// Purpose: Transceiver end: power bits, calibration, lock, keying choice
// Assumes: Link strobes synchronous to i_clk
// Notes:   Analog sections are modelled by enable and status outputs
`timescale 1ns/1ns
module rf_device_end
  import rfseq_pkg::*;
#(
  parameter int CAL_TIME  = CAL_CYCLES,
  parameter int LOCK_TIME = LOCK_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  rf_cfg_if.device        link,
  input  wire logic       i_tx_data,
  input  wire logic [7:0] i_rx_level,
  input  wire logic       i_rx_fsk_bit,
  output logic            o_rx_on,
  output logic            o_tx_on,
  output logic            o_synth_on,
  output logic            o_xosc_on,
  output logic [3:0]      o_osc_bias,
  output logic            o_ook,
  output logic            o_carrier_on,
  output logic            o_rx_sample,
  output logic            o_ref_bypass,
  output logic            o_lock
);
  logic [7:0]  regs [0:NUM_REGS-1];
  logic        cal_done;
  logic        cal_busy;
  logic [15:0] cal_cnt;
  logic [15:0] lock_cnt;
  logic        lock;
  logic        wr_hit;

  function automatic logic [7:0] reg_default(input int idx);
    case (idx)
      0:       reg_default = MAIN_PD_VAL;
      1:       reg_default = DEV_RST;
      2:       reg_default = GAIN2_RST;
      3:       reg_default = GAIN4_RST;
      4:       reg_default = BIAS_RST;
      5:       reg_default = IFACE_RST;
      6:       reg_default = MODEM_RST;
      7:       reg_default = FILTER_RST;
      default: reg_default = 8'h00;
    endcase
  endfunction : reg_default

  assign wr_hit = link.wr && !link.sel_n;

  // Register file; soft reset returns all but power control to defaults
  generate
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          regs[g] <= reg_default(g);
        end else if (wr_hit && link.addr == 4'(g)) begin
          regs[g] <= link.wdata; // A write wins this cycle, but writes to other registers are lost while the soft reset bit is low
        end else if (g != 0 && !regs[0][MAIN_RESET_N]) begin
          regs[g] <= reg_default(g);
        end else if (g == 8) begin
          regs[g] <= 8'h00; // Start bit is a one-shot
        end
      end
    end
  endgenerate

  // Link answers: ack and read data one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      link.ack   <= 1'b0;
      link.rdata <= 8'h00;
    end else begin
      link.ack   <= (link.wr || link.rd) && !link.sel_n;
      if (link.rd && !link.sel_n) begin
        if (link.addr == REG_STATUS) begin
          link.rdata <= {6'h00, lock, cal_done};
        end else if (link.addr < 4'(NUM_REGS)) begin
          link.rdata <= regs[link.addr];
        end else begin
          link.rdata <= 8'h00;
        end
      end
    end
  end

  // Calibration timer; a new start clears done, finishing sets it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !regs[0][MAIN_RESET_N]) begin
      cal_busy <= 1'b0;
      cal_done <= 1'b0;
      cal_cnt  <= 16'h0000;
    end else if (cal_busy) begin
      if (cal_cnt == 16'(CAL_TIME - 1)) begin
        cal_busy <= 1'b0;
        cal_done <= 1'b1;
      end
      cal_cnt <= cal_cnt + 16'h0001;
    end else if (regs[8][CAL_START]) begin
      cal_busy <= 1'b1;
      cal_done <= 1'b0;
      cal_cnt  <= 16'h0000;
    end
  end

  // Relock after any change of mode or synthesizer power
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lock     <= 1'b0;
      lock_cnt <= 16'h0000;
    end else if (regs[0][MAIN_FS_PD] || (wr_hit && link.addr == REG_MAIN)) begin
      lock     <= 1'b0;
      lock_cnt <= 16'h0000;
    end else if (!lock) begin
      lock     <= lock_cnt == 16'(LOCK_TIME - 1);
      lock_cnt <= lock_cnt + 16'h0001;
    end
  end

  // Section enables and keying path, all registered
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rx_on      <= 1'b0;
      o_tx_on      <= 1'b0;
      o_synth_on   <= 1'b0;
      o_xosc_on    <= 1'b0;
      o_osc_bias   <= 4'h0;
      o_ook        <= 1'b0;
      o_carrier_on <= 1'b0;
      o_rx_sample  <= 1'b0;
      o_ref_bypass <= 1'b0;
      o_lock       <= 1'b0;
    end else begin
      o_rx_on      <= !regs[0][MAIN_RX_PD];
      o_tx_on      <= !regs[0][MAIN_TX_PD];
      o_synth_on   <= !regs[0][MAIN_FS_PD];
      o_xosc_on    <= !regs[0][MAIN_XOSC_PD];
      o_osc_bias   <= regs[0][MAIN_WORD2] ? regs[4][7:4] : regs[4][3:0];
      o_ook        <= regs[1][3:0] == DEV_MANT_OOK;
      // Full depth keying: carrier fully off for a zero
      o_carrier_on <= !regs[0][MAIN_TX_PD] && (regs[1][3:0] != DEV_MANT_OOK || i_tx_data);
      // Level against carrier sense threshold in keyed mode
      o_rx_sample  <= (regs[1][3:0] == DEV_MANT_OOK) ? (i_rx_level >= regs[3]) : i_rx_fsk_bit;
      o_ref_bypass <= regs[5][IFACE_REF_SKIP];
      o_lock       <= lock;
    end
  end
endmodule : rf_device_end

// *** hdl/rf_host_end.sv ***
// Purpose: Host sequencer driving power-up, calibration and mode changes
// Assumes: Software port strobes one cycle long, never together
// Notes:   One link transaction in flight; each waits for its ack
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module rf_host_end
  import rfseq_pkg::*;
#(
  parameter int RELOCK_WAIT = RELOCK_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  rf_cfg_if.host          link,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata
);
  typedef enum {S_IDLE, S_FETCH, S_WR_ACK, S_CAL_WR, S_POLL, S_POLL_ACK, S_RELOCK} state_t;

  state_t      state;
  logic [4:0]  pc;
  logic [7:0]  cfg;
  mode_t       mode;
  mode_t       target;
  logic        refused;
  logic [15:0] wait_cnt;
  logic [13:0] op;
  op_t         op_kind;
  logic        cmd_hit;
  logic        cmd_ok;
  logic [4:0]  start_pc;
  logic        on_off_keying;
  logic [2:0]  baud;

  assign on_off_keying  = cfg[0];
  assign baud = cfg[3:1];

  // Step program: {kind, register, value}; values follow configuration
  function automatic logic [13:0] prog(input logic [4:0] p, input logic k, input logic [2:0] b,
                                       input logic dig);
    logic [7:0] filt;
    filt = {6'h00, (k && b <= BAUD_9K6_IDX) ? FILT_X4 : FILT_X2};
    case (p)
      5'd0:    prog = {OP_WR, REG_MAIN, MAIN_RESET_VAL};
      5'd1:    prog = {OP_WR, REG_MAIN, MAIN_PD_VAL};
      // Only registers that the configuration can move from defaults
      5'd2:    prog = {OP_WR, REG_DEV, k ? {DEV_RST[7:4], DEV_MANT_OOK} : DEV_RST};
      5'd3:    prog = {OP_WR, REG_GAIN2, k ? {GAIN2_RST[7:2], GAIN_AVG_OOK} : GAIN2_RST};
      5'd4:    prog = {OP_WR, REG_FILTER, k ? filt : FILTER_RST};
      // Manchester on and tracking off when keyed
      5'd5:    prog = {OP_WR, REG_MODEM, {3'h0, b, !k, k}};
      5'd6:    prog = {OP_WR, REG_IFACE, {7'h00, dig}};
      5'd7:    prog = {OP_WR, REG_MAIN, MAIN_WAKE_RX};
      5'd8:    prog = {OP_CAL, 4'h0, 8'h00};
      5'd9:    prog = {OP_WR, REG_MAIN, MAIN_WAKE_TX};
      5'd10:   prog = {OP_CAL, 4'h0, 8'h00};
      5'd11:   prog = {OP_WR, REG_MAIN, MAIN_PD_VAL};
      5'd13:   prog = {OP_WR, REG_MAIN, MAIN_WAKE_RX};
      5'd14:   prog = {OP_WR, REG_MAIN, MAIN_SETUP_RX};
      5'd16:   prog = {OP_WR, REG_MAIN, MAIN_WAKE_TX};
      5'd17:   prog = {OP_WR, REG_MAIN, MAIN_SETUP_TX};
      5'd19:   prog = {OP_WR, REG_MAIN, MAIN_SETUP_RX};
      5'd20:   prog = {OP_RELOCK, 4'h0, 8'h00};
      5'd22:   prog = {OP_WR, REG_MAIN, MAIN_SETUP_TX};
      5'd23:   prog = {OP_RELOCK, 4'h0, 8'h00};
      5'd25:   prog = {OP_WR, REG_MAIN, MAIN_PD_VAL};
      default: prog = {OP_END, 4'h0, 8'h00};
    endcase
  endfunction : prog

  assign op      = prog(pc, on_off_keying, baud, cfg[4]);
  assign op_kind = op_t'(op[13:12]);
  assign cmd_hit = i_wr && i_addr == HOST_CMD;

  // Entry point by command and present mode; none when not allowed
  always_comb begin
    cmd_ok   = 1'b0;
    start_pc = 5'd12;
    if (state == S_IDLE) begin
      case (i_wdata[1:0])
        CMD_INIT: begin
          cmd_ok   = 1'b1;
          start_pc = 5'd0;
        end
        CMD_RX: begin
          cmd_ok   = mode != M_UNINIT && mode != M_RX;
          start_pc = (mode == M_TX) ? 5'd19 : 5'd13;
        end
        CMD_TX: begin
          cmd_ok   = mode != M_UNINIT && mode != M_TX;
          start_pc = (mode == M_RX) ? 5'd22 : 5'd16;
        end
        CMD_PD: begin
          cmd_ok   = mode != M_UNINIT;
          start_pc = 5'd25;
        end
        default: begin
          cmd_ok   = 1'b0;
          start_pc = 5'd12;
        end
      endcase
    end
  end

  // Configuration register; held while a sequence runs
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg <= CFG_RST;
    end else if (i_wr && i_addr == HOST_CFG && state == S_IDLE) begin
      // Baud index 0 is the slowest keyed rate, so none lies below it
      cfg <= {3'h0, i_wdata[4:0]};
    end
  end

  // Software read port, data one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        HOST_CFG:    o_rdata <= cfg;
        HOST_STATUS: o_rdata <= {3'h0, mode != M_UNINIT, refused, 2'(mode), state != S_IDLE};
        default:     o_rdata <= 8'h00;
      endcase
    end
  end

  // Refused command flag; an accepted command clears it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      refused <= 1'b0;
    end else if (cmd_hit) begin
      refused <= !cmd_ok;
    end
  end

  // Sequencer: write steps complete on the device ack, calibration steps on a status read showing done; relock steps end on the wait count
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state      <= S_IDLE;
      pc         <= 5'd0;
      mode       <= M_UNINIT;
      target     <= M_UNINIT;
      wait_cnt   <= 16'h0000;
      link.sel_n <= 1'b1; // Held high while idle or powered down
      link.wr    <= 1'b0;
      link.rd    <= 1'b0;
      link.addr  <= 4'h0;
      link.wdata <= 8'h00;
    end else begin
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      case (state)
        S_IDLE: begin
          if (cmd_hit && cmd_ok) begin
            pc     <= start_pc;
            target <= (i_wdata[1:0] == CMD_RX) ? M_RX : (i_wdata[1:0] == CMD_TX) ? M_TX : M_PD;
            state  <= S_FETCH;
          end
        end
        S_FETCH: begin
          case (op_kind)
            OP_WR: begin
              link.sel_n <= 1'b0;
              link.wr    <= 1'b1;
              link.addr  <= op[11:8];
              link.wdata <= op[7:0];
              state      <= S_WR_ACK;
            end
            OP_CAL: begin
              // Start bit written after frequency is set up
              link.sel_n <= 1'b0;
              link.wr    <= 1'b1;
              link.addr  <= REG_CAL;
              link.wdata <= 8'h01;
              state      <= S_CAL_WR;
            end
            OP_RELOCK: begin
              wait_cnt <= 16'h0000;
              state    <= S_RELOCK;
            end
            default: begin
              link.sel_n <= 1'b1;
              mode       <= target;
              state      <= S_IDLE;
            end
          endcase
        end
        S_WR_ACK: begin
          if (link.ack) begin
            pc    <= pc + 5'd1;
            state <= S_FETCH;
          end
        end
        S_CAL_WR: begin
          if (link.ack) begin
            state <= S_POLL;
          end
        end
        S_POLL: begin
          link.rd   <= 1'b1;
          link.addr <= REG_STATUS;
          state     <= S_POLL_ACK;
        end
        S_POLL_ACK: begin
          if (link.ack) begin
            // Nothing else issued until done is seen
            if (link.rdata[STAT_CAL_DONE]) begin
              pc    <= pc + 5'd1;
              state <= S_FETCH;
            end else begin
              state <= S_POLL;
            end
          end
        end
        S_RELOCK: begin
          wait_cnt <= wait_cnt + 16'h0001;
          if (wait_cnt == 16'(RELOCK_WAIT - 1)) begin
            pc    <= pc + 5'd1;
            state <= S_FETCH; // Link usable only after relock
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule : rf_host_end

// *** verif/rf_mode_power_sequencer_sva.sv ***
// Purpose: Link protocol and sequence-order checks between host and device ends
// Assumes: One clock, synchronous active-low reset
// Notes:   Sees only the link signals; helper flops track the last power word
`timescale 1ns/1ns
module rf_mode_power_sequencer_sva
  import rfseq_pkg::*;
#(
  parameter int RELOCK_WAIT = RELOCK_CYCLES
) (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       sel_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       ack
);
  logic [7:0]  last_main;
  logic        reset_seen;
  logic        cal_pend;
  logic        was_rd;
  logic [15:0] relock_cnt;
  logic        main_wr;
  logic        cal_wr;
  logic        swap_wr;
  logic        keyed;
  logic [7:0]  last_filt;

  // Decoded link writes
  assign main_wr = wr && !sel_n && addr == REG_MAIN;
  assign cal_wr  = wr && !sel_n && addr == REG_CAL && wdata[CAL_START];
  assign swap_wr = main_wr && ((wdata == MAIN_SETUP_TX && last_main == MAIN_SETUP_RX) ||
                               (wdata == MAIN_SETUP_RX && last_main == MAIN_SETUP_TX));

  // Last power word; starts at the device default, all sections down
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) last_main <= MAIN_PD_VAL;
    else if (main_wr) last_main <= wdata;
  end

  // Soft reset seen since the last hard reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) reset_seen <= 1'b0;
    else if (main_wr && !wdata[MAIN_RESET_N]) reset_seen <= 1'b1;
  end

  // Calibration pending until a status read returns done
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cal_pend <= 1'b0;
      was_rd   <= 1'b0;
    end else begin
      if (wr || rd) was_rd <= rd;
      if (cal_wr) cal_pend <= 1'b1;
      else if (ack && was_rd && rdata[STAT_CAL_DONE]) cal_pend <= 1'b0;
    end
  end

  // Keying choice and filter code from the latest configuration writes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      keyed     <= 1'b0;
      last_filt <= FILTER_RST;
    end else if (wr && !sel_n && addr == REG_DEV) begin
      keyed <= wdata[3:0] == DEV_MANT_OOK;
    end else if (wr && !sel_n && addr == REG_FILTER) begin
      last_filt <= wdata;
    end
  end

  // Relock window; counted here since the wait is longer than a repetition may be
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) relock_cnt <= 16'h0000;
    else if (swap_wr) relock_cnt <= RELOCK_WAIT[15:0];
    else if (relock_cnt != 16'h0000) relock_cnt <= relock_cnt - 16'h0001;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_ack_follows: assert property ((wr || rd) && !sel_n |=> ack)
    else $error("link strobe not acknowledged next cycle");
  a_ack_caused: assert property (ack |-> ($past(wr) || $past(rd)) && !$past(sel_n))
    else $error("acknowledge without a selected strobe");
  a_strobe_single: assert property ((wr || rd) |-> !(wr && rd) ##1 !(wr || rd))
    else $error("link strobes overlap or last too long");
  a_strobe_selected: assert property ((wr || rd) |-> !sel_n)
    else $error("link strobe while select is high");
  a_reset_first: assert property (wr && !reset_seen |-> addr == REG_MAIN && !wdata[MAIN_RESET_N])
    else $error("configuration before soft reset");
  a_wake_tx_order: assert property (main_wr && wdata == MAIN_WAKE_TX
    |-> last_main == MAIN_PD_VAL || last_main == MAIN_WAKE_RX)
    else $error("transmit wake from wrong state");
  a_setup_rx_order: assert property (main_wr && wdata == MAIN_SETUP_RX
    |-> last_main == MAIN_WAKE_RX || last_main == MAIN_SETUP_TX)
    else $error("receive setup without wake or switch");
  a_setup_tx_order: assert property (main_wr && wdata == MAIN_SETUP_TX
    |-> last_main == MAIN_WAKE_TX || last_main == MAIN_SETUP_RX)
    else $error("transmit setup without wake or switch");
  a_cal_when_awake: assert property (cal_wr |-> last_main == MAIN_WAKE_RX || last_main == MAIN_WAKE_TX)
    else $error("calibration started outside a wake state");
  a_cal_done_wait: assert property (main_wr |-> !cal_pend)
    else $error("power word written during calibration");
  a_relock_hold: assert property ((wr || rd) |-> relock_cnt == 16'h0000)
    else $error("link used before relock wait ended");
  a_keyed_avg: assert property (wr && !sel_n && addr == REG_GAIN2 && keyed
    |-> wdata[1:0] == GAIN_AVG_OOK)
    else $error("keyed mode without gain averaging of three");
  a_keyed_filter: assert property (wr && !sel_n && addr == REG_MODEM && keyed
    |-> last_filt[1:0] == ((wdata[MODEM_BAUD_LSB +: 3] <= BAUD_9K6_IDX) ? FILT_X4 : FILT_X2))
    else $error("keyed filter width does not match baud rate");
  a_keyed_coding: assert property (wr && !sel_n && addr == REG_MODEM && keyed
    |-> wdata[MODEM_MANCH] && !wdata[MODEM_TRACK])
    else $error("keyed data without coding or with offset tracking");

  // Main scenarios reached
  c_cal_start: cover property (cal_wr);
  c_cal_done: cover property (ack && was_rd && rdata[STAT_CAL_DONE]);
  c_swap: cover property (swap_wr);
endmodule : rf_mode_power_sequencer_sva

// *** verif/rf_mode_power_sequencer_tb.sv ***
// Purpose: Drives the host software port and checks both ends together
// Assumes: Short relock and calibration parameters keep the run small
// Notes:   Device side inputs are driven directly by the bench
`timescale 1ns/1ns
module rf_mode_power_sequencer_tb;
  import rfseq_pkg::*;
  localparam int RELOCK_T = 20;
  localparam int LIMIT    = 20000;
  logic       i_clk;
  logic       i_rst_n;
  logic [1:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic [7:0] o_rdata;
  logic       i_tx_data;
  logic [7:0] i_rx_level;
  logic       i_rx_fsk_bit;
  logic       o_rx_on, o_tx_on, o_synth_on, o_xosc_on, o_ook, o_carrier_on, o_rx_sample, o_ref_bypass, o_lock;
  logic [3:0] o_osc_bias;
  int         n_mismatch;
  int         cmp_count;
  int         cycles;
  int         n;

  rf_cfg_if rf_cfg_if_i ();
  rf_host_end #(.RELOCK_WAIT(RELOCK_T)) rf_host_end_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(rf_cfg_if_i),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  rf_device_end #(.CAL_TIME(10), .LOCK_TIME(5)) rf_device_end_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .link(rf_cfg_if_i), .i_tx_data(i_tx_data), .i_rx_level(i_rx_level), .i_rx_fsk_bit(i_rx_fsk_bit),
    .o_rx_on(o_rx_on), .o_tx_on(o_tx_on), .o_synth_on(o_synth_on), .o_xosc_on(o_xosc_on),
    .o_osc_bias(o_osc_bias), .o_ook(o_ook), .o_carrier_on(o_carrier_on), .o_rx_sample(o_rx_sample),
    .o_ref_bypass(o_ref_bypass), .o_lock(o_lock));
  rf_mode_power_sequencer_sva #(.RELOCK_WAIT(RELOCK_T)) rf_mode_power_sequencer_sva_i (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .sel_n(rf_cfg_if_i.sel_n), .addr(rf_cfg_if_i.addr), .wdata(rf_cfg_if_i.wdata),
    .wr(rf_cfg_if_i.wr), .rd(rf_cfg_if_i.rd), .rdata(rf_cfg_if_i.rdata), .ack(rf_cfg_if_i.ack));

  // 10 MHz clock
  initial i_clk = 1'b0;
  always #50 i_clk = ~i_clk;

  // Hang guard; a stuck sequence would otherwise never end
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic sw_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : sw_wr

  // Read data appear the cycle after the strobe and hold until the next read
  task automatic sw_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : sw_rd

  task automatic st(input logic [7:0] exp);
    logic [7:0] v;
    sw_rd(HOST_STATUS, v);
    check("status", exp, v);
  endtask : st

  // Poll busy under a bound; returns cycles spent
  task automatic wait_idle(output int cnt);
    logic [7:0] v;
    repeat (3) @(posedge i_clk);
    cnt = 3;
    do begin
      sw_rd(HOST_STATUS, v);
      cnt += 2;
    end while (v[0] !== 1'b0 && cnt < 2000);
    if (cnt >= 2000) check("idle", 8'h00, v);
  endtask : wait_idle

  task automatic do_cmd(input logic [1:0] c, input logic [7:0] es, input logic [7:0] ep, output int cnt);
    sw_wr(HOST_CMD, {6'h00, c});
    wait_idle(cnt);
    st(es);
    check("power", ep, {4'h0, o_xosc_on, o_synth_on, o_tx_on, o_rx_on});
  endtask : do_cmd

  task automatic settle_chk(input string name, input logic exp, ref logic sig);
    repeat (3) @(posedge i_clk);
    check(name, {7'h00, exp}, {7'h00, sig});
  endtask : settle_chk

  // Main sequence
  initial begin
    i_rst_n      = 1'b0;
    i_addr       = 2'h0;
    i_wdata      = 8'h00;
    i_wr         = 1'b0;
    i_rd         = 1'b0;
    i_tx_data    = 1'b0;
    i_rx_level   = 8'h00;
    i_rx_fsk_bit = 1'b0;
    n_mismatch   = 0;
    cmp_count    = 0;
    cycles       = 0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    st(8'h00);
    check("power", 8'h00, {4'h0, o_xosc_on, o_synth_on, o_tx_on, o_rx_on});
    sw_wr(HOST_CMD, {6'h00, CMD_RX});
    st(8'h08);
    sw_wr(HOST_CFG, 8'h15);
    do_cmd(CMD_INIT, 8'h12, 8'h00, n);
    check("keyed", 8'h03, {6'h00, o_ook, o_ref_bypass});
    do_cmd(CMD_RX, 8'h14, 8'h0d, n);
    check("bias", {4'h0, BIAS_RST[3:0]}, {4'h0, o_osc_bias});
    i_rx_level <= GAIN4_RST;
    settle_chk("sample_hi", 1'b1, o_rx_sample);
    i_rx_level   <= GAIN4_RST - 8'h01;
    i_rx_fsk_bit <= 1'b1;
    settle_chk("sample_lo", 1'b0, o_rx_sample);
    do_cmd(CMD_RX, 8'h1c, 8'h0d, n);
    do_cmd(CMD_TX, 8'h16, 8'h0e, n);
    check("relock", 8'h01, {7'h00, n >= RELOCK_T});
    check("bias", {4'h0, BIAS_RST[7:4]}, {4'h0, o_osc_bias});
    settle_chk("carrier_off", 1'b0, o_carrier_on);
    i_tx_data <= 1'b1;
    settle_chk("carrier_on", 1'b1, o_carrier_on);
    check("lock", 8'h01, {7'h00, o_lock});
    do_cmd(CMD_PD, 8'h12, 8'h00, n);
    check("sel_n", 8'h01, {7'h00, rf_cfg_if_i.sel_n});
    check("lock", 8'h00, {7'h00, o_lock});
    do_cmd(CMD_TX, 8'h16, 8'h0e, n);
    do_cmd(CMD_RX, 8'h14, 8'h0d, n);
    check("relock", 8'h01, {7'h00, n >= RELOCK_T});
    sw_wr(HOST_CMD, {6'h00, CMD_PD});
    sw_wr(HOST_CMD, {6'h00, CMD_TX});
    wait_idle(n);
    st(8'h1a);
    // Second reset in mid-run, then a plain frequency-shift setup
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    st(8'h00);
    sw_wr(HOST_CFG, 8'h06);
    do_cmd(CMD_INIT, 8'h12, 8'h00, n);
    check("keyed", 8'h00, {6'h00, o_ook, o_ref_bypass});
    do_cmd(CMD_TX, 8'h16, 8'h0e, n);
    i_tx_data <= 1'b0;
    settle_chk("carrier_fsk", 1'b1, o_carrier_on);
    settle_chk("sample_fsk", 1'b1, o_rx_sample);
    end_of_test();
  end
endmodule : rf_mode_power_sequencer_tb
